// ==== verilog/csbe_pkg.sv ====
`default_nettype none
package csbe_pkg;
    // Instruction kinds handled by the block
    typedef enum logic [2:0] {
        OP_NONE,
        OP_COMPARE_SKIP_EQUAL,
        OP_COMPARE_IMMEDIATE,
        OP_SKIP_REG_BIT_CLEAR,
        OP_SKIP_IO_BIT_CLEAR,
        OP_BRANCH_FLAG_SET,
        OP_BRANCH_FLAG_CLEAR
    } csbe_op_type;

    // Status register field positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_H = 5;

    // Flags written by the immediate compare
    localparam logic [7:0] CMP_FLAG_MASK = 8'h2f;

    // Program counter steps in words
    localparam logic [1:0] PC_STEP_NORMAL   = 2'h1;
    localparam logic [1:0] PC_SKIP_ONE_WORD = 2'h2;
    localparam logic [1:0] PC_SKIP_TWO_WORD = 2'h3;

    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage : csbe_pkg
`default_nettype wire

// ==== verilog/csbe_alu_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface csbe_alu_if;
    logic [7:0] lhs;
    logic [7:0] rhs;
    logic       equal;
    logic       c_flag;
    logic       z_flag;
    logic       n_flag;
    logic       v_flag;
    logic       h_flag;

    modport alu  (input lhs, input rhs,
                  output equal, output c_flag, output z_flag,
                  output n_flag, output v_flag, output h_flag);
    modport user (output lhs, output rhs,
                  input equal, input c_flag, input z_flag,
                  input n_flag, input v_flag, input h_flag);
endinterface : csbe_alu_if
`default_nettype wire

// ==== verilog/csbe_cmp_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
module csbe_cmp_alu (
    csbe_alu_if.alu port_b
);
    // ****************************************
    // Subtraction without storing the result
    // ****************************************
    wire [7:0] diff;
    wire [7:0] a;
    wire [7:0] b;

    assign a    = port_b.lhs;
    assign b    = port_b.rhs;
    assign diff = a - b;

    assign port_b.equal  = (a == b);
    assign port_b.z_flag = (diff == 8'h00);
    assign port_b.n_flag = diff[7];
    assign port_b.v_flag = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
    assign port_b.c_flag = (~a[7] & b[7]) | (b[7] & diff[7]) | (diff[7] & ~a[7]);
    assign port_b.h_flag = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
endmodule : csbe_cmp_alu
`default_nettype wire

// ==== verilog/csbe_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module csbe_exec #(
    parameter int PC_W  = 16,
    parameter int OFS_W = 7
) (
    input  wire logic                core_clk_i,
    input  wire logic                reset_n_i,
    input  wire logic                exec_valid_i,
    input  wire csbe_pkg::csbe_op_type op_i,
    input  wire logic [PC_W-1:0]     pc_i,
    input  wire logic [7:0]          reg_d_i,
    input  wire logic [7:0]          reg_r_i,
    input  wire logic [7:0]          imm_i,
    input  wire logic [7:0]          io_value_i,
    input  wire logic [2:0]          bit_sel_i,
    input  wire logic [OFS_W-1:0]    offset_i,
    input  wire logic [7:0]          status_register_i,
    input  wire logic                next_two_word_i,
    output logic                     done_o,
    output logic [PC_W-1:0]          pc_next_o,
    output logic                     taken_o,
    output logic [7:0]               status_register_o,
    output logic                     status_we_o
);
    // ****************************************
    // Compare unit
    // ****************************************
    csbe_alu_if alu_bus ();

    csbe_cmp_alu u_alu (
        .port_b (alu_bus)
    );

    // ****************************************
    // Decode
    // ****************************************
    wire is_cse  = (op_i == csbe_pkg::OP_COMPARE_SKIP_EQUAL);
    wire is_cmpi = (op_i == csbe_pkg::OP_COMPARE_IMMEDIATE);
    wire is_rbit = (op_i == csbe_pkg::OP_SKIP_REG_BIT_CLEAR);
    wire is_sio  = (op_i == csbe_pkg::OP_SKIP_IO_BIT_CLEAR);
    wire is_bset = (op_i == csbe_pkg::OP_BRANCH_FLAG_SET);
    wire is_bclr = (op_i == csbe_pkg::OP_BRANCH_FLAG_CLEAR);

    assign alu_bus.lhs = reg_d_i;
    assign alu_bus.rhs = is_cmpi ? imm_i : reg_r_i;

    wire sel_reg_bit  = reg_r_i[bit_sel_i];
    wire sel_io_bit   = io_value_i[bit_sel_i];
    wire sel_flag_bit = status_register_i[bit_sel_i];

    wire skip_cse  = is_cse & alu_bus.equal;
    wire skip_rbit = is_rbit & ~sel_reg_bit;
    wire skip_sio  = is_sio & ~sel_io_bit;
    wire skip_any  = skip_cse | skip_rbit | skip_sio;

    wire br_set = is_bset & sel_flag_bit;
    wire br_clr = is_bclr & ~sel_flag_bit;
    wire br_any = br_set | br_clr;

    // ****************************************
    // Step and target
    // ****************************************
    // skip step size
    wire [1:0] skip_step = next_two_word_i ? csbe_pkg::PC_SKIP_TWO_WORD
                                          : csbe_pkg::PC_SKIP_ONE_WORD;
    wire [1:0] pc_step   = skip_any ? skip_step : csbe_pkg::PC_STEP_NORMAL;

    wire [PC_W-1:0] ofs_ext   = PC_W'($signed(offset_i));
    wire [PC_W-1:0] br_target = pc_i + ofs_ext + PC_W'(1);
    wire [PC_W-1:0] seq_next  = pc_i + PC_W'(pc_step);

    // ****************************************
    // Status update
    // ****************************************
    // compare immediate flags
    wire [7:0] cmp_flags = {2'h0, alu_bus.h_flag, 1'b0, alu_bus.v_flag,
                            alu_bus.n_flag, alu_bus.z_flag, alu_bus.c_flag};
    wire [7:0] status_new = (status_register_i & ~csbe_pkg::CMP_FLAG_MASK)
                          | (cmp_flags & csbe_pkg::CMP_FLAG_MASK);

    // ****************************************
    // Result registers
    // ****************************************
    logic            done_d;
    logic            done_q;
    logic [PC_W-1:0] pc_d;
    logic [PC_W-1:0] pc_q;
    logic            taken_d;
    logic            taken_q;
    logic [7:0]      st_d;
    logic [7:0]      st_q;
    logic            we_d;
    logic            we_q;

    assign done_d  = exec_valid_i & (op_i != csbe_pkg::OP_NONE);
    assign pc_d    = br_any ? br_target : seq_next;
    assign taken_d = done_d & (br_any | skip_any);
    assign we_d    = done_d & is_cmpi;
    assign st_d    = is_cmpi ? status_new : status_register_i;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            done_q  <= 1'b0;
            pc_q    <= '0;
            taken_q <= 1'b0;
            st_q    <= csbe_pkg::STATUS_RESET;
            we_q    <= 1'b0;
        end else begin
            done_q  <= done_d;
            pc_q    <= pc_d;
            taken_q <= taken_d;
            st_q    <= st_d;
            we_q    <= we_d;
        end
    end

    assign done_o            = done_q;
    assign pc_next_o         = pc_q;
    assign taken_o           = taken_q;
    assign status_register_o = st_q;
    assign status_we_o       = we_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_equal_skip_step: assert property (
        exec_valid_i && is_cse && reg_d_i == reg_r_i && !next_two_word_i
        |=> pc_next_o == $past(pc_i) + PC_W'(2) && taken_o && !status_we_o)
        else $error("Equal compare did not skip by two");

    chk_imm_flag_write: assert property (
        exec_valid_i && is_cmpi
        |=> status_we_o && status_register_o[csbe_pkg::FLAG_Z]
            == ($past(reg_d_i) == $past(imm_i))
            && status_register_o[7:6] == $past(status_register_i[7:6])
            && status_register_o[4] == $past(status_register_i[4]))
        else $error("Immediate compare flags wrong");

    chk_reg_bit_skip: assert property (
        exec_valid_i && is_rbit && !reg_r_i[bit_sel_i] && next_two_word_i
        |=> pc_next_o == $past(pc_i) + PC_W'(3) && !status_we_o)
        else $error("Register bit clear skip wrong");

    chk_sio_noskip: assert property (
        exec_valid_i && is_sio && io_value_i[bit_sel_i]
        |=> pc_next_o == $past(pc_i) + PC_W'(1) && !taken_o)
        else $error("I/O bit set must not skip");

    chk_bset_target: assert property (
        exec_valid_i && is_bset && status_register_i[bit_sel_i]
        |=> taken_o && pc_next_o
            == $past(pc_i) + PC_W'($signed($past(offset_i))) + PC_W'(1))
        else $error("Flag set branch target wrong");

    chk_bclr_target: assert property (
        exec_valid_i && is_bclr && !status_register_i[bit_sel_i]
        |=> taken_o && !status_we_o && pc_next_o
            == $past(pc_i) + PC_W'($signed($past(offset_i))) + PC_W'(1))
        else $error("Flag clear branch target wrong");

    chk_skip_width: assert property (
        done_o && taken_o && !status_we_o
        && ($past(is_cse) || $past(is_rbit) || $past(is_sio))
        |-> pc_next_o - $past(pc_i) == ($past(next_two_word_i) ? PC_W'(3) : PC_W'(2)))
        else $error("Skip step does not match skipped size");

    chk_equal_no_skip: assert property (
        exec_valid_i && is_cse && reg_d_i != reg_r_i
        |=> done_o && !taken_o && pc_next_o == $past(pc_i) + PC_W'(1))
        else $error("Unequal compare must not skip");

    chk_imm_carry_half: assert property (
        exec_valid_i && is_cmpi
        |=> status_register_o[csbe_pkg::FLAG_C] == ($past(reg_d_i) < $past(imm_i))
            && status_register_o[csbe_pkg::FLAG_H]
               == ($past(reg_d_i[3:0]) < $past(imm_i[3:0])))
        else $error("Immediate compare borrow flags wrong");

    chk_reg_bit_set: assert property (
        exec_valid_i && is_rbit && reg_r_i[bit_sel_i]
        |=> !taken_o && pc_next_o == $past(pc_i) + PC_W'(1))
        else $error("Register bit set must not skip");

    chk_io_skip: assert property (
        exec_valid_i && is_sio && !io_value_i[bit_sel_i]
        |=> taken_o && !status_we_o
            && pc_next_o == $past(pc_i) + ($past(next_two_word_i) ? PC_W'(3) : PC_W'(2)))
        else $error("I/O bit clear skip wrong");

    chk_branch_idle: assert property (
        exec_valid_i && ((is_bset && !status_register_i[bit_sel_i])
                         || (is_bclr && status_register_i[bit_sel_i]))
        |=> !taken_o && pc_next_o == $past(pc_i) + PC_W'(1))
        else $error("Branch taken on wrong flag value");

    chk_flags_kept: assert property (
        done_o && !status_we_o |-> status_register_o == $past(status_register_i))
        else $error("Flags changed by a non-compare instruction");

    chk_we_only_imm: assert property (
        status_we_o |-> $past(exec_valid_i) && $past(is_cmpi))
        else $error("Status write without immediate compare");

    // ****************************************
    // Covers
    // ****************************************
    cov_equal_skip:  cover property (exec_valid_i && skip_cse);
    cov_imm_run:     cover property (exec_valid_i && is_cmpi ##1 status_we_o);
    cov_branch_back: cover property (exec_valid_i && br_any && offset_i[OFS_W-1]);
    cov_branch:    cover property (exec_valid_i && br_any ##1 taken_o);
    cov_skip_two:  cover property (exec_valid_i && skip_sio && next_two_word_i);
endmodule : csbe_exec
`default_nettype wire

// ==== testbench/compare_skip_branch_exec_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench for the compare, skip and branch block
// ****************************************
module compare_skip_branch_exec_bench;
    logic                  clk   = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  vld   = 1'b0;
    logic                  two   = 1'b0;
    csbe_pkg::csbe_op_type op    = csbe_pkg::OP_NONE;
    logic [15:0]           pc    = 16'h0000;
    logic [7:0]            d     = 8'h00;
    logic [7:0]            r     = 8'h00;
    logic [7:0]            imm   = 8'h00;
    logic [7:0]            io    = 8'h00;
    logic [7:0]            sr    = 8'h00;
    logic [2:0]            bs    = 3'h0;
    logic [6:0]            ofs   = 7'h00;
    logic                  done;
    logic                  tkn;
    logic                  we;
    logic [15:0]           pcn;
    logic [7:0]            sro;
    logic [26:0]           got;
    int                    n_mismatch = 0;
    int                    n_tests    = 0;

    always #20 clk = ~clk;

    csbe_exec dut (.core_clk_i(clk), .reset_n_i(rst_n),
        .exec_valid_i(vld), .op_i(op), .pc_i(pc), .reg_d_i(d), .reg_r_i(r), .imm_i(imm),
        .io_value_i(io), .bit_sel_i(bs), .offset_i(ofs), .status_register_i(sr),
        .next_two_word_i(two), .done_o(done), .pc_next_o(pcn), .taken_o(tkn),
        .status_register_o(sro), .status_we_o(we));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [26:0] seen, input logic [26:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Issue one instruction at a falling edge, sample one cycle later
    task automatic run(input csbe_pkg::csbe_op_type o);
        vld = 1'b1;
        op  = o;
        @(negedge clk);
        got = {done, tkn, we, pcn, sro};
    endtask : run

    function automatic logic [7:0] cmp(input logic [7:0] s, input logic [7:0] a,
                                       input logic [7:0] k);
        logic [7:0] q;
        logic [7:0] f;
        int         sd;
        q = a - k;
        sd = $signed(a) - $signed(k);
        f = s & ~csbe_pkg::CMP_FLAG_MASK;
        f[csbe_pkg::FLAG_C] = a < k;
        f[csbe_pkg::FLAG_Z] = q == 8'h00;
        f[csbe_pkg::FLAG_N] = q[7];
        f[csbe_pkg::FLAG_V] = (sd > 127) || (sd < -128);
        f[csbe_pkg::FLAG_H] = a[3:0] < k[3:0];
        return f;
    endfunction : cmp

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_skip_equal();
        for (int i = 0; i < 4; i++) begin
            two = i[0];
            d = 8'h5a;
            r = i[1] ? 8'h5b : 8'h5a;
            pc = 16'h0100;
            sr = 8'h3c;
            run(csbe_pkg::OP_COMPARE_SKIP_EQUAL);
            check(got, {1'b1, !i[1], 1'b0, 16'h0100 + (i[1] ? 16'h1 : 16'h2 + i[0]), 8'h3c});
        end
    endtask : t_skip_equal

    task automatic t_cmp_imm();
        logic [15:0] tab [4] = '{16'h0505, 16'h1001, 16'h8001, 16'h0001};
        for (int i = 0; i < 4; i++) begin
            d = tab[i][15:8];
            imm = tab[i][7:0];
            sr = 8'hd0;
            pc = 16'h0200;
            run(csbe_pkg::OP_COMPARE_IMMEDIATE);
            check(got, {3'b101, 16'h0201, cmp(8'hd0, tab[i][15:8], tab[i][7:0])});
        end
    endtask : t_cmp_imm

    task automatic t_skip_bit(input logic io_side);
        for (int b = 0; b < 16; b++) begin
            bs = b[2:0];
            two = b[0];
            r = (8'h01 << b[2:0]) ^ {8{b[3] | io_side}};
            io = (8'h01 << b[2:0]) ^ {8{b[3]}};
            sr = 8'ha5;
            pc = 16'h0300;
            run(io_side ? csbe_pkg::OP_SKIP_IO_BIT_CLEAR : csbe_pkg::OP_SKIP_REG_BIT_CLEAR);
            check(got, {1'b1, b[3], 1'b0, 16'h0301 + (b[3] ? 16'h1 + b[0] : 16'h0), 8'ha5});
        end
    endtask : t_skip_bit

    task automatic t_branch();
        for (int b = 0; b < 32; b++) begin
            bs = b[2:0];
            sr = (8'h01 << b[2:0]) ^ {8{b[3]}};
            pc = b[4] ? 16'h0000 : 16'h0010;
            ofs = b[4] ? 7'h7d : 7'h3f;
            run(b[0] ? csbe_pkg::OP_BRANCH_FLAG_CLEAR : csbe_pkg::OP_BRANCH_FLAG_SET);
            check(got, {1'b1, b[3] == b[0], 1'b0, b[3] != b[0] ? pc + 16'h1 :
                  (b[4] ? 16'hfffe : 16'h0050), sr});
        end
    endtask : t_branch

    task automatic t_none();
        run(csbe_pkg::OP_NONE);
        check({got[26:24], 24'h0}, 27'h0);
        vld = 1'b0;
        op  = csbe_pkg::OP_COMPARE_IMMEDIATE;
        @(negedge clk);
        check({done, tkn, we, 24'h0}, 27'h0);
    endtask : t_none

    // Reset in mid-run drops a pending branch, then a branch runs again
    task automatic t_reset();
        sr    = 8'h01;
        bs    = 3'h0;
        pc    = 16'h0040;
        ofs   = 7'h02;
        rst_n = 1'b0;
        run(csbe_pkg::OP_BRANCH_FLAG_SET);
        check(got, 27'h0);
        rst_n = 1'b1;
        vld   = 1'b0;
        @(negedge clk);
        check({done, tkn, we, 24'h0}, 27'h0);
        run(csbe_pkg::OP_BRANCH_FLAG_SET);
        check(got, {3'b110, 16'h0043, 8'h01});
    endtask : t_reset

    task automatic finish_test();
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    initial begin
        #(40 * 3000);
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (10) @(negedge clk);
        check({done, tkn, we, pcn, sro}, 27'h0);
        rst_n = 1'b1;
        @(negedge clk);
        check({done, tkn, we, pcn, sro}, {3'b000, 16'h0001, 8'h00});
        t_skip_equal();
        t_cmp_imm();
        t_skip_bit(1'b0);
        t_skip_bit(1'b1);
        t_branch();
        t_none();
        t_reset();
        finish_test();
    end
endmodule : compare_skip_branch_exec_bench
`default_nettype wire
